// File: dv/dds_control_register_bank_properties.sv
// Checker for the synthesizer register bank, bound to its top module.
// Assumes one clock domain, i_ref_clk, and the async reset i_nrst.
`timescale 1ns/100ps
module dds_control_register_bank_properties
  import dds_regs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_external_powerdown_pin,
  input wire logic o_sdio,
  input wire logic o_sdio_oe_n,
  input wire logic o_sdo,
  input wire logic o_sync_clk,
  input wire logic [PHASE_W-1:0] o_phase,
  input wire logic [ASF_SCALE_HI:0] o_scale,
  input wire logic o_scale_bypass,
  input wire logic o_digital_halt,
  input wire logic o_pll_pd,
  input wire logic [C2_MUL_HI-C2_MUL_LO:0] o_ref_mult,
  input wire logic o_pll_bypass
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // A forced-low pin counts as a legal end of period
  a_sync_period:
  assert property ($rose(o_sync_clk) |-> ##1 (!$rose(o_sync_clk)) [*3]
    ##1 ($rose(o_sync_clk) || !o_sync_clk)) else $error("sync clock period not four");
  a_bypass_full:
  assert property (o_scale_bypass |-> o_scale == SCALE_FULL)
    else $error("scale not full while bypassed");
  a_mult_bypass:
  assert property (o_pll_bypass == (o_ref_mult < MUL_MIN || o_ref_mult > MUL_MAX))
    else $error("multiplier bypass decode wrong");
  a_sdo_mirror:
  assert property (!o_sdio_oe_n |-> o_sdo == o_sdio) else $error("read pins differ");
  a_oe_release:
  assert property ($rose(i_cs_n) |-> ##[1:3] o_sdio_oe_n) else $error("data pin not released");
  a_idle_no_drive:
  assert property (i_cs_n [*3] |-> o_sdio_oe_n) else $error("data pin driven outside frame");
  a_ext_halt:
  assert property ($rose(i_external_powerdown_pin) |-> ##[1:3] o_digital_halt)
    else $error("power-down pin did not halt");
  a_pll_idle:
  assert property ((!i_external_powerdown_pin) [*3] |-> !o_pll_pd)
    else $error("loop powered down without pin");
  a_halt_freeze:
  assert property (o_digital_halt [*3] |-> $stable(o_phase)) else $error("phase moved in halt");

  c_halt: cover property ($rose(o_digital_halt));
  c_keying_on: cover property ($fell(o_scale_bypass));
  c_pll_pd: cover property ($rose(o_pll_pd));
  c_read_drive: cover property (!o_sdio_oe_n);
endmodule

bind dds_control_register_bank dds_control_register_bank_properties i_props (
  .i_ref_clk, .i_nrst, .i_cs_n, .i_external_powerdown_pin, .o_sdio, .o_sdio_oe_n,
  .o_sdo, .o_sync_clk, .o_phase, .o_scale, .o_scale_bypass, .o_digital_halt,
  .o_pll_pd, .o_ref_mult, .o_pll_bypass
);

// File: dv/dds_control_register_bank_tb_top.sv
// Testbench for the synthesizer register bank, serial access by host model.
// Assumes a 40 MHz system clock; inputs change at falling edges.
`timescale 1ns/100ps
module dds_control_register_bank_tb_top;
  import dds_regs_pkg::*;
  logic i_ref_clk, i_nrst, i_sync_in, i_shaped_keying, i_external_powerdown_pin;
  logic sclk, cs_n, sdio_h, io_upd, o_sdio, o_sdio_oe_n, o_sdo, o_sync_clk, o_sine_sel;
  logic o_scale_bypass, o_dac_pd, o_clk_in_pd, o_pll_pd, o_digital_halt, o_vco_high;
  logic o_high_speed_sync, o_crystal_out_en, o_pll_bypass, oe_low;
  logic [13:0] o_phase, o_scale, p0;
  logic [4:0] o_ref_mult, m;
  logic [1:0] o_cp_current;
  int err_total = 0, checked = 0, nf, ns, n;

  dds_control_register_bank i_dut (.i_ref_clk, .i_nrst, .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdio(sdio_h), .o_sdio, .o_sdio_oe_n, .o_sdo, .i_io_update(io_upd), .i_sync_in,
    .i_shaped_keying, .i_external_powerdown_pin, .o_sync_clk, .o_phase, .o_sine_sel,
    .o_scale, .o_scale_bypass, .o_dac_pd, .o_clk_in_pd, .o_pll_pd, .o_digital_halt,
    .o_high_speed_sync, .o_crystal_out_en, .o_ref_mult, .o_pll_bypass, .o_vco_high,
    .o_cp_current);
  dds_host_model i_host (.i_ref_clk, .i_sdio_dev(o_sdio), .i_sdio_oe_n(o_sdio_oe_n),
    .i_sdo(o_sdo), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio_h), .o_io_update(io_upd));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
    if (o_sdio_oe_n === 1'b0)
      oe_low <= 1'b1;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    i_host.wait_n(c);
  endtask
  task automatic wr(input logic [4:0] a, input logic [5:0] nb, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b0, a, nb, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [5:0] nb, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b1, a, nb, 32'h0, q);
    chk(q, e, "read back");
  endtask
  task automatic cfg1(input logic [31:0] d);
    wr(ADDR_CFR_ONE, BITS_CFR_ONE, d);
    i_host.pulse_update();
  endtask
  task automatic ramp_to(input logic [13:0] t, output int c);
    c = 0;
    while (o_scale !== t && c < 3000)
    begin
      cyc(1);
      c++;
      if (o_scale > 14'h0044)
        chk(o_scale, 14'h0044, "ramp above ceiling");
    end
    if (c >= 3000)
    begin
      chk(o_scale, t, "ramp timeout");
      tally_and_finish();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {i_nrst, i_sync_in, i_shaped_keying, i_external_powerdown_pin, oe_low} = '0;
    cyc(2);
    i_nrst = 1'b1;
    cyc(2);
    chk({o_scale_bypass, o_scale, o_pll_bypass}, {1'b1, SCALE_FULL, 1'b1}, "reset out");
    rd(ADDR_CFR_ONE, BITS_CFR_ONE, RST_CFR_ONE);
    rd(ADDR_CFR_TWO, BITS_CFR_TWO, RST_CFR_TWO);
    rd(ADDR_ASF, BITS_ASF, RST_ASF);
    rd(ADDR_ARR, BITS_ARR, RST_ARR);
    rd(ADDR_FTW, BITS_FTW, RST_FTW);
    rd(ADDR_POW, BITS_POW, RST_POW);
    wr(5'h1F, BITS_UNMAPPED, 32'hFF);
    rd(5'h1F, BITS_UNMAPPED, 32'h0);
    wr(ADDR_CFR_TWO, BITS_CFR_TWO, 32'h180AA7);
    rd(ADDR_CFR_TWO, BITS_CFR_TWO, 32'h180AA7);
    i_host.pulse_update();
    chk({o_high_speed_sync, o_crystal_out_en, o_vco_high}, 3'h7, "ctl2 bits");
    for (int i = 0; i < 4; i++)
    begin
      m = (i == 0) ? 5'h03 : (i == 1) ? 5'h04 : (i == 2) ? 5'h14 : 5'h15;
      wr(ADDR_CFR_TWO, BITS_CFR_TWO, {8'h18, 8'h00, m, 1'b0, 2'(i)});
      i_host.pulse_update();
      chk({o_ref_mult, o_pll_bypass}, {m, i == 0 || i == 3}, "multiplier");
      chk({o_cp_current, o_vco_high}, {2'(i), 1'b0}, "pump current");
    end
    wr(ADDR_POW, BITS_POW, 32'h1000);
    i_host.pulse_update();
    chk(o_phase, 14'h1000, "phase offset");
    wr(ADDR_FTW, BITS_FTW, 32'h0004_0000);
    rd(ADDR_FTW, BITS_FTW, 32'h0004_0000);
    chk(o_phase, 14'h1000, "tuning before update");
    i_host.pulse_update();
    p0 = o_phase;
    cyc(1);
    chk(o_phase, 14'(p0 + 14'h0001), "accumulate");
    cfg1(32'h1 << C1_CLR_ACC);
    chk(o_phase, 14'h1000, "clear held");
    cfg1(32'h0);
    p0 = o_phase;
    cyc(1);
    chk(o_phase, 14'(p0 + 14'h0001), "clear released");
    cfg1(32'h1 << C1_SINE_SEL | 32'h1 << C1_DIG_PD | 32'h1 << C1_DAC_PD | 32'h1 << C1_CLKIN_PD);
    p0 = o_phase;
    chk({o_sine_sel, o_digital_halt, o_dac_pd, o_clk_in_pd}, 4'hF, "pd bits");
    cyc(3);
    chk(o_phase, p0, "halt freeze");
    cfg1(32'h0);
    chk({o_sine_sel, o_digital_halt, o_dac_pd, o_clk_in_pd}, 4'h0, "pd clear");
    for (int i = 0; i < 2; i++)
    begin
      if (i == 1)
        cfg1(32'h1 << C1_EXT_PD_FULL);
      i_external_powerdown_pin = 1'b1;
      cyc(6);
      chk({o_digital_halt, o_pll_pd}, {1'b1, 1'(i)}, "pin power-down");
      i_external_powerdown_pin = 1'b0;
      cyc(6);
    end
    wr(ADDR_ASF, BITS_ASF, 32'hC044);
    wr(ADDR_ARR, BITS_ARR, 32'h02);
    cfg1(32'h1 << C1_KEY_EN);
    chk({o_scale_bypass, o_scale}, {1'b0, 14'h0044}, "manual scale");
    cfg1(32'h3 << C1_KEY_AUTO);
    chk(o_scale, 14'h0, "auto idle");
    i_shaped_keying = 1'b1;
    ramp_to(14'h0044, nf);
    i_shaped_keying = 1'b0;
    ramp_to(14'h0, n);
    wr(ADDR_ARR, BITS_ARR, 32'h08);
    i_host.pulse_update();
    i_shaped_keying = 1'b1;
    ramp_to(14'h0044, ns);
    chk(ns > 2 * nf, 1, "ramp rate");
    i_shaped_keying = 1'b0;
    ramp_to(14'h0, n);
    cfg1(32'h1 << C1_LSB_FIRST | 32'h1 << C1_SDIO_IN_ONLY);
    i_host.lsb_first = 1'b1;
    i_host.three_wire = 1'b1;
    chk({o_scale_bypass, oe_low}, 2'h3, "bypass, two-wire drive");
    oe_low = 1'b0;
    cfg1(32'h1 << C1_LSB_FIRST | 32'h1 << C1_SDIO_IN_ONLY | 32'h1 << C1_SINE_SEL);
    chk(o_sine_sel, 1'b1, "lsb first write");
    rd(ADDR_ARR, BITS_ARR, 32'h08);
    chk(oe_low, 1'b0, "three-wire no drive");
    cfg1(32'h1 << C1_SYNC_OUT_DIS);
    n = 0;
    for (int i = 0; i < 12; i++)
    begin
      cyc(1);
      n += o_sync_clk;
    end
    chk(n, 0, "sync pin static");
    tally_and_finish();
  end
endmodule

// File: dv/dds_host_model.sv
// Host model: drives the serial port and the update pin by tasks.
// Assumes the bench calls its tasks from one process, after a falling edge.
`timescale 1ns/100ps
module dds_host_model
  import dds_regs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sdio_dev,
  input wire logic i_sdio_oe_n,
  input wire logic i_sdo,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdio,
  output logic o_io_update
);
  logic lsb_first = 1'b0;
  logic three_wire = 1'b0;
  logic drv = 1'b0;

  assign o_sdio = i_sdio_oe_n ? drv : i_sdio_dev;

  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io_update = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // Released line toggles so a stale level never passes for data.
  // Read bits stand from one clock fall to the next, so the bit is taken
  // before this fall moves the device on to the next one.
  task automatic bit_io(input logic rd, input logic b, output logic q);
    drv = rd ? ~drv : b;
    q = three_wire ? i_sdo : i_sdio_dev;
    o_sclk = 1'b0;
    wait_n(3);
    o_sclk = 1'b1;
    wait_n(2);
  endtask

  task automatic xfer(input logic rd, input logic [4:0] a, input logic [5:0] n,
    input logic [31:0] wd, output logic [31:0] q);
    logic [7:0] ins;
    logic b;
    int k;
    ins = {rd, 2'b00, a};
    q = '0;
    o_cs_n = 1'b0;
    wait_n(2);
    for (int i = 0; i < 8; i++)
      bit_io(1'b0, ins[lsb_first ? i : 7 - i], b);
    for (int i = 0; i < n; i++)
    begin
      k = lsb_first ? i : n - 1 - i;
      bit_io(rd, wd[k], b);
      q[k] = b;
    end
    o_cs_n = 1'b1;
    wait_n(1);
    o_sclk = 1'b0;
    wait_n(2);
  endtask

  // one sync rise high, then two sync periods low
  task automatic pulse_update();
    o_io_update = 1'b1;
    wait_n(4);
    o_io_update = 1'b0;
    wait_n(8);
  endtask
endmodule

// File: hw/dds_control_register_bank.sv
// Control register bank of a direct digital synthesizer core, with its
// serial port, update transfer, sync clock divider, keying ramp and
// phase accumulator. All pins but the async reset i_nrst are taken as synchronous to i_ref_clk,
// which is the system clock; serial clock edges are found by sampling.
`timescale 1ns/100ps

module dds_control_register_bank
  import dds_regs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe_n,
  output logic o_sdo,
  input wire logic i_io_update,
  input wire logic i_sync_in,
  input wire logic i_shaped_keying,
  input wire logic i_external_powerdown_pin,
  output logic o_sync_clk,
  output logic [PHASE_W-1:0] o_phase,
  output logic o_sine_sel,
  output logic [ASF_SCALE_HI:0] o_scale,
  output logic o_scale_bypass,
  output logic o_dac_pd,
  output logic o_clk_in_pd,
  output logic o_pll_pd,
  output logic o_digital_halt,
  output logic o_high_speed_sync,
  output logic o_crystal_out_en,
  output logic [C2_MUL_HI-C2_MUL_LO:0] o_ref_mult,
  output logic o_pll_bypass,
  output logic o_vco_high,
  output logic [C2_CP_HI:0] o_cp_current
);

  // ----------------------------------------------------------------
  // Register storage: buffers written by the port, active copies
  // ----------------------------------------------------------------
  logic [31:0] buf_control_function_one_q;
  logic [23:0] buf_control_function_two_q;
  logic [15:0] buf_asf_q;
  logic [7:0] buf_arr_q;
  logic [31:0] buf_ftw_q;
  logic [13:0] buf_pow_q;
  logic [31:0] control_function_one_q;
  logic [23:0] control_function_two_q;
  logic [15:0] asf_q;
  logic [7:0] arr_q;
  logic [31:0] ftw_q;
  logic [13:0] pow_q;

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  sp_state_e sp_q;
  logic sclk_q;
  logic [31:0] sr_q;
  logic [5:0] cnt_q;
  logic [5:0] nbits_q;
  logic rd_q;
  logic [4:0] addr_q;
  logic [31:0] rd_word_q;
  logic sclk_rise;
  logic sclk_fall;
  logic lsb_first;
  logic [31:0] sr_d;
  logic [31:0] word_in;
  logic [31:0] rd_mux;
  logic [5:0] nbits_mux;
  logic [7:0] instr_in;
  logic wr_done;
  logic [5:0] out_idx;

  assign sclk_rise = i_sclk & ~sclk_q;
  assign sclk_fall = ~i_sclk & sclk_q;
  // bit order from the written control bit
  assign lsb_first = buf_control_function_one_q[C1_LSB_FIRST];
  assign sr_d = lsb_first ? {i_sdio, sr_q[31:1]} : {sr_q[30:0], i_sdio};
  // LSB-first frames collect from the top and need right alignment
  assign word_in = lsb_first ? (sr_d >> (6'd32 - (cnt_q + 6'd1))) : sr_d;
  assign instr_in = word_in[7:0];
  assign wr_done = (sp_q == SP_DATA) && sclk_rise && !rd_q && (cnt_q + 6'd1 == nbits_q);
  assign out_idx = lsb_first ? cnt_q : (nbits_q - 6'd1 - cnt_q);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    nbits_mux = BITS_UNMAPPED;
    unique case (instr_in[INSTR_ADDR_HI:0])
      ADDR_CFR_ONE:
      begin
        rd_mux = buf_control_function_one_q;
        nbits_mux = BITS_CFR_ONE;
      end
      ADDR_CFR_TWO:
      begin
        rd_mux = {8'h00, buf_control_function_two_q};
        nbits_mux = BITS_CFR_TWO;
      end
      ADDR_ASF:
      begin
        rd_mux = {16'h0000, buf_asf_q};
        nbits_mux = BITS_ASF;
      end
      ADDR_ARR:
      begin
        rd_mux = {24'h00_0000, buf_arr_q};
        nbits_mux = BITS_ARR;
      end
      ADDR_FTW:
      begin
        rd_mux = buf_ftw_q;
        nbits_mux = BITS_FTW;
      end
      ADDR_POW:
      begin
        rd_mux = {18'h0_0000, buf_pow_q};
        nbits_mux = BITS_POW;
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
        nbits_mux = BITS_UNMAPPED;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sp_q <= SP_IDLE;
      sclk_q <= 1'b0;
      sr_q <= 32'h0000_0000;
      cnt_q <= 6'h00;
      nbits_q <= BITS_UNMAPPED;
      rd_q <= 1'b0;
      addr_q <= 5'h00;
      rd_word_q <= 32'h0000_0000;
    end
    else
    begin
      sclk_q <= i_sclk;
      if (i_cs_n)
      begin
        sp_q <= SP_IDLE;
        cnt_q <= 6'h00;
        rd_q <= 1'b0;
      end
      else
      begin
        unique case (sp_q)
          SP_IDLE:
          begin
            sp_q <= SP_INSTR;
            cnt_q <= 6'h00;
            sr_q <= 32'h0000_0000;
          end
          SP_INSTR:
          begin
            if (sclk_rise)
            begin
              sr_q <= sr_d;
              cnt_q <= cnt_q + 6'd1;
              if (cnt_q + 6'd1 == BITS_INSTR)
              begin
                sp_q <= SP_DATA;
                cnt_q <= 6'h00;
                sr_q <= 32'h0000_0000;
                rd_q <= instr_in[INSTR_READ];
                addr_q <= instr_in[INSTR_ADDR_HI:0];
                nbits_q <= nbits_mux;
                rd_word_q <= rd_mux;
              end
            end
          end
          SP_DATA:
          begin
            if (rd_q ? sclk_fall : sclk_rise)
            begin
              sr_q <= sr_d;
              cnt_q <= cnt_q + 6'd1;
              // Back-to-back instruction after each complete word
              if (cnt_q + 6'd1 == nbits_q)
              begin
                sp_q <= SP_INSTR;
                cnt_q <= 6'h00;
                sr_q <= 32'h0000_0000;
                rd_q <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end

  // two-wire turns the data pin round, three-wire uses the out pin
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_sdio <= 1'b0;
      o_sdio_oe_n <= 1'b1;
      o_sdo <= 1'b0;
    end
    else
    begin
      o_sdio <= rd_word_q[out_idx[4:0]];
      o_sdo <= rd_word_q[out_idx[4:0]];
      o_sdio_oe_n <= !(rd_q && (sp_q == SP_DATA) && !i_cs_n &&
                       !buf_control_function_one_q[C1_SDIO_IN_ONLY]);
    end
  end

  // ----------------------------------------------------------------
  // Sync clock divider and alignment
  // ----------------------------------------------------------------
  logic [1:0] div_q;
  logic sync_in_q;
  logic sync_in_rise;
  logic sync_rise;
  logic upd_seen_q;
  logic upd_tick;
  logic sw_sync_go;

  assign sync_in_rise = i_sync_in & ~sync_in_q;
  assign sync_rise = (div_q == DIV_RISE);
  // update pin sampled at sync clock rise, one transfer per edge
  assign upd_tick = sync_rise & i_io_update & ~upd_seen_q;
  assign sw_sync_go = control_function_one_q[C1_SW_SYNC];

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      div_q <= DIV_RISE;
      sync_in_q <= 1'b0;
      upd_seen_q <= 1'b0;
    end
    else
    begin
      sync_in_q <= i_sync_in;
      if (sync_rise)
        upd_seen_q <= i_io_update;
      // automatic alignment restarts the divider at the sync input
      if (control_function_one_q[C1_AUTO_SYNC] && sync_in_rise)
        div_q <= DIV_RISE;
      // hardware sync slips one reference period per sync input rise
      else if (control_function_two_q[C2_HW_SYNC] && sync_in_rise)
        div_q <= div_q + DIV_REF_ADV;
      // software sync brings the next rising edge forward
      else if (sw_sync_go)
        div_q <= DIV_RISE;
      // free divide-by-four of the system clock
      else
        div_q <= div_q + DIV_STEP;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_sync_clk <= 1'b0;
    else
      o_sync_clk <= ~div_q[1] & ~control_function_one_q[C1_SYNC_OUT_DIS];
  end

  // ----------------------------------------------------------------
  // Buffer writes and update transfer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      buf_control_function_one_q <= RST_CFR_ONE;
      buf_control_function_two_q <= RST_CFR_TWO;
      buf_asf_q <= RST_ASF;
      buf_arr_q <= RST_ARR;
      buf_ftw_q <= RST_FTW;
      buf_pow_q <= RST_POW;
    end
    else
    begin
      // self-clear after the advance; a fresh write wins
      if (sw_sync_go)
        buf_control_function_one_q[C1_SW_SYNC] <= 1'b0;
      if (wr_done)
      begin
        unique case (addr_q)
          ADDR_CFR_ONE: buf_control_function_one_q <= word_in;
          ADDR_CFR_TWO: buf_control_function_two_q <= word_in[23:0];
          ADDR_ASF: buf_asf_q <= word_in[15:0];
          ADDR_ARR: buf_arr_q <= word_in[7:0];
          ADDR_FTW: buf_ftw_q <= word_in;
          ADDR_POW: buf_pow_q <= word_in[13:0];
          default: buf_pow_q <= buf_pow_q;
        endcase
      end
    end
  end

  // new values, tuning word included, act after an update; C1_LSB_FIRST and C1_SDIO_IN_ONLY act on write
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      control_function_one_q <= RST_CFR_ONE;
      control_function_two_q <= RST_CFR_TWO;
      asf_q <= RST_ASF;
      arr_q <= RST_ARR;
      ftw_q <= RST_FTW;
      pow_q <= RST_POW;
    end
    else if (upd_tick)
    begin
      control_function_one_q <= buf_control_function_one_q;
      control_function_two_q <= buf_control_function_two_q;
      asf_q <= buf_asf_q;
      arr_q <= buf_arr_q;
      ftw_q <= buf_ftw_q;
      pow_q <= buf_pow_q;
    end
    else if (sw_sync_go)
      control_function_one_q[C1_SW_SYNC] <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Power-down decode
  // ----------------------------------------------------------------
  logic ext_pd;
  logic ext_full;
  logic halt;

  assign ext_pd = i_external_powerdown_pin;
  assign ext_full = ext_pd & control_function_one_q[C1_EXT_PD_FULL];
  // digital suspend leaves the serial port running
  assign halt = control_function_one_q[C1_DIG_PD] | ext_pd;

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_dac_pd <= 1'b0;
      o_clk_in_pd <= 1'b0;
      o_pll_pd <= 1'b0;
      o_digital_halt <= 1'b0;
    end
    else
    begin
      // full mode also drops the loop, converter and clock input
      o_dac_pd <= control_function_one_q[C1_DAC_PD] | ext_full;
      o_clk_in_pd <= control_function_one_q[C1_CLKIN_PD] | ext_full;
      o_pll_pd <= ext_full;
      o_digital_halt <= halt;
    end
  end

  // ----------------------------------------------------------------
  // Analog settings
  // ----------------------------------------------------------------
  logic [C2_MUL_HI-C2_MUL_LO:0] mul;

  assign mul = control_function_two_q[C2_MUL_HI:C2_MUL_LO];

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_ref_mult <= RST_CFR_TWO[C2_MUL_HI:C2_MUL_LO];
      o_pll_bypass <= 1'b1;
      o_vco_high <= 1'b0;
      o_cp_current <= RST_CFR_TWO[C2_CP_HI:0];
      o_high_speed_sync <= 1'b0;
      o_crystal_out_en <= 1'b0;
    end
    else
    begin
      o_ref_mult <= mul;
      o_pll_bypass <= (mul < MUL_MIN) || (mul > MUL_MAX);
      // range bit and charge pump step straight through
      o_vco_high <= control_function_two_q[C2_VCO_HIGH];
      o_cp_current <= control_function_two_q[C2_CP_HI:0];
      o_high_speed_sync <= control_function_two_q[C2_HS_SYNC];
      o_crystal_out_en <= control_function_two_q[C2_XTAL_OUT];
    end
  end

  // ----------------------------------------------------------------
  // Phase accumulator and offset
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] acc_q;
  logic autoclr_q;

  // one-cycle clear flagged by an update with auto-clear set
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      autoclr_q <= 1'b0;
    else
      autoclr_q <= upd_tick & buf_control_function_one_q[C1_AUTOCLR_ACC];
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      acc_q <= '0;
    // held at zero while the clear bit stands
    else if (control_function_one_q[C1_CLR_ACC] || autoclr_q)
      acc_q <= '0;
    else if (!halt)
      acc_q <= acc_q + ftw_q;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_phase <= '0;
      o_sine_sel <= 1'b0;
    end
    else
    begin
      // offset in units of a full turn over two to the fourteenth
      o_phase <= acc_q[ACC_W-1 -: PHASE_W] + pow_q;
      o_sine_sel <= control_function_one_q[C1_SINE_SEL];
    end
  end

  // ----------------------------------------------------------------
  // Shaped keying ramp
  // ----------------------------------------------------------------
  logic [7:0] ramp_tmr_q;
  logic [13:0] ramp_q;
  logic key_q;
  logic auto_q;
  logic auto_mode;
  logic tmr_out;
  logic tmr_load;
  logic [13:0] step;
  logic [13:0] ceil;

  assign auto_mode = control_function_one_q[C1_KEY_EN] & control_function_one_q[C1_KEY_AUTO];
  assign tmr_out = (ramp_tmr_q <= RAMP_TIMEOUT);
  // forced reloads: update if enabled, pin change, entering auto
  assign tmr_load = tmr_out || (upd_tick && buf_control_function_one_q[C1_LOAD_RAMP_AT_UPD]) ||
                    (i_shaped_keying != key_q) || (auto_mode && !auto_q);
  // top bits pick step 1, 2, 4 or 8; low field is the ceiling
  assign step = 14'h0001 << asf_q[ASF_STEP_HI:ASF_STEP_LO];
  assign ceil = asf_q[ASF_SCALE_HI:0];

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ramp_tmr_q <= RST_ARR;
      key_q <= 1'b0;
      auto_q <= 1'b0;
    end
    else
    begin
      key_q <= i_shaped_keying;
      auto_q <= auto_mode;
      // reload interval from the ramp rate register
      if (tmr_load)
        ramp_tmr_q <= arr_q;
      else if (auto_mode && !halt)
        ramp_tmr_q <= ramp_tmr_q - RAMP_TIMEOUT;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ramp_q <= '0;
    else if (!auto_mode)
      ramp_q <= '0;
    // pin high ramps up, low ramps down, on each timeout
    else if (tmr_out && !halt)
    begin
      // clamp at both ends, never wrap
      if (i_shaped_keying)
        ramp_q <= (ramp_q >= ceil || ceil - ramp_q < step) ? ceil : ramp_q + step;
      else
        ramp_q <= (ramp_q < step) ? 14'h0000 : ramp_q - step;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_scale <= SCALE_FULL;
      o_scale_bypass <= 1'b1;
    end
    else
    begin
      o_scale_bypass <= ~control_function_one_q[C1_KEY_EN];
      if (!control_function_one_q[C1_KEY_EN])
        o_scale <= SCALE_FULL;
      else if (auto_mode)
        o_scale <= ramp_q;
      // manual mode uses the programmed scale
      else
        o_scale <= ceil;
    end
  end

endmodule

// File: hw/dds_regs_pkg.sv
// Constants for the synthesizer control register bank: serial register
// addresses, bit counts, field positions, reset values and divider phases.
// Shared by the design and the verification side.
package dds_regs_pkg;

  // Serial register addresses
  localparam logic [4:0] ADDR_CFR_ONE = 5'h00;
  localparam logic [4:0] ADDR_CFR_TWO = 5'h01;
  localparam logic [4:0] ADDR_ASF = 5'h02;
  localparam logic [4:0] ADDR_ARR = 5'h03;
  localparam logic [4:0] ADDR_FTW = 5'h04;
  localparam logic [4:0] ADDR_POW = 5'h05;

  // Bits carried by each register in a serial frame
  localparam logic [5:0] BITS_CFR_ONE = 6'h20;
  localparam logic [5:0] BITS_CFR_TWO = 6'h18;
  localparam logic [5:0] BITS_ASF = 6'h10;
  localparam logic [5:0] BITS_ARR = 6'h08;
  localparam logic [5:0] BITS_FTW = 6'h20;
  localparam logic [5:0] BITS_POW = 6'h10;
  localparam logic [5:0] BITS_UNMAPPED = 6'h08;
  localparam logic [5:0] BITS_INSTR = 6'h08;

  // Instruction byte layout
  localparam int INSTR_READ = 7;
  localparam int INSTR_ADDR_HI = 4;

  // Control function one fields
  localparam int C1_LOAD_RAMP_AT_UPD = 26;
  localparam int C1_KEY_EN = 25;
  localparam int C1_KEY_AUTO = 24;
  localparam int C1_AUTO_SYNC = 23;
  localparam int C1_SW_SYNC = 22;
  localparam int C1_AUTOCLR_ACC = 13;
  localparam int C1_SINE_SEL = 12;
  localparam int C1_CLR_ACC = 10;
  localparam int C1_SDIO_IN_ONLY = 9;
  localparam int C1_LSB_FIRST = 8;
  localparam int C1_DIG_PD = 7;
  localparam int C1_DAC_PD = 5;
  localparam int C1_CLKIN_PD = 4;
  localparam int C1_EXT_PD_FULL = 3;
  localparam int C1_SYNC_OUT_DIS = 1;

  // Control function two fields
  localparam int C2_HS_SYNC = 11;
  localparam int C2_HW_SYNC = 10;
  localparam int C2_XTAL_OUT = 9;
  localparam int C2_MUL_HI = 7;
  localparam int C2_MUL_LO = 3;
  localparam int C2_VCO_HIGH = 2;
  localparam int C2_CP_HI = 1;

  // Amplitude scale factor fields
  localparam int ASF_STEP_HI = 15;
  localparam int ASF_STEP_LO = 14;
  localparam int ASF_SCALE_HI = 13;

  // Phase path widths
  localparam int PHASE_W = 14;
  localparam int ACC_W = 32;

  // Reference multiplier legal range
  localparam logic [4:0] MUL_MIN = 5'h04;
  localparam logic [4:0] MUL_MAX = 5'h14;

  // Reset values
  localparam logic [31:0] RST_CFR_ONE = 32'h0000_0000;
  localparam logic [23:0] RST_CFR_TWO = 24'h18_0000;
  localparam logic [15:0] RST_ASF = 16'h0000;
  localparam logic [7:0] RST_ARR = 8'h00;
  localparam logic [31:0] RST_FTW = 32'h0000_0000;
  localparam logic [13:0] RST_POW = 14'h0000;

  // Sync clock divider (system clock divided by four), ramp timeout and full scale
  localparam logic [1:0] DIV_RISE = 2'h0;
  localparam logic [1:0] DIV_STEP = 2'h1;
  localparam logic [1:0] DIV_REF_ADV = 2'h2;
  localparam logic [7:0] RAMP_TIMEOUT = 8'h01;
  localparam logic [13:0] SCALE_FULL = 14'h3FFF;

  typedef enum logic [2:0]
  {
    SP_IDLE = 3'b001,
    SP_INSTR = 3'b010,
    SP_DATA = 3'b100
  } sp_state_e;

endpackage
